/* File: verilog/lsps_pkg.sv */
// Constants, register map and state types of the cam switch program selector.
// Assumes one 200 MHz clock and a 32-bit classic Wishbone register bus.
package lsps_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ          = 200_000_000;
	localparam int          CYC_PER_MS      = CLK_HZ / 1000;
	localparam int          STARTUP_MS      = 500;
	localparam int          SWITCH_MIN_MS   = 30;
	localparam int          SWITCH_MAX_MS   = 1000;
	localparam logic [26:0] STARTUP_CYC     = 27'(STARTUP_MS * CYC_PER_MS);
	localparam logic [26:0] SWITCH_MIN_CYC  = 27'(SWITCH_MIN_MS * CYC_PER_MS);
	localparam logic [26:0] CNT_ZERO        = 27'h0000000;
	localparam logic [26:0] CNT_ONE         = 27'h0000001;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int          CH_NUM          = 16;
	localparam int          POS_W           = 16;
	localparam int          WORD_W          = 16;
	localparam logic [3:0]  CH_LAST         = 4'hF;

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [5:0]  IDX_ANSWER      = 6'h01;
	localparam logic [5:0]  IDX_CAM_STATE   = 6'h04;
	localparam logic [5:0]  IDX_STATUS      = 6'h07;
	localparam logic [5:0]  IDX_PROG_SET    = 6'h09;
	localparam logic [5:0]  IDX_DOG_BASE    = 6'h0C;
	localparam logic [5:0]  IDX_DOG_LAST    = 6'h2B;

	// ----------------------------------------------------------------
	// Values and fields
	// ----------------------------------------------------------------
	localparam logic [15:0] PROG_SET_RST    = 16'h0000;
	localparam logic [15:0] PROG_ZERO       = 16'h0000;
	localparam logic [15:0] PROG_MAX        = 16'h0008;
	localparam logic [15:0] ANS_SWITCHING   = 16'h0009;
	localparam logic [15:0] ANS_RST         = 16'h0000;
	localparam logic [7:0]  ERR_BASE        = 8'h3C;
	localparam logic [7:0]  ERR_NONE        = 8'h00;
	localparam logic [15:0] DOG_RST         = 16'h0000;
	localparam int          ST_ONLINE_BIT   = 8;
	localparam int          ST_BUSY_BIT     = 9;
	localparam int          ST_VALID_BIT    = 10;

	// ----------------------------------------------------------------
	// Loader states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {LD_IDLE, LD_WAIT, LD_FETCH, LD_TAKE} lsps_ld_state_t;

endpackage : lsps_pkg

/* File: verilog/lsps_load_if.sv */
// Link between the program controller and the cam table loader.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lsps_load_if;
	logic        start;
	logic [3:0]  prog;
	logic        busy;
	logic        done;
	logic        fail;
	logic [7:0]  err_code;
	logic [3:0]  ch;
	logic [3:0]  ch_prog;
	logic        wr_en;
	logic        src_valid;

	modport loader (input start, prog, src_valid,
		output busy, done, fail, err_code, ch, ch_prog, wr_en);
	modport ctrl (output start, prog, src_valid,
		input busy, done, fail, err_code, ch, ch_prog, wr_en);
endinterface : lsps_load_if

/* File: verilog/lsps_loader.sv */
// Cam table loader: waits the least switching time, then walks the channels up to the last one or to the first invalid one.
// Assumes the source data answer within one cycle of a channel change.
`timescale 1ns/1ps
module lsps_loader #(
	parameter logic [26:0] MIN_CYC = lsps_pkg::SWITCH_MIN_CYC
) (
	// Clock and reset
	input wire logic    clk_i,
	input wire logic    rst_i,
	// Controller side
	lsps_load_if.loader ld
);
	lsps_pkg::lsps_ld_state_t state, next_state;
	logic [26:0]              cnt, next_cnt;
	logic [3:0]               ch, next_ch;
	logic [3:0]               prog, next_prog;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_ch    = ch;
		next_prog  = prog;
		case (state)
			lsps_pkg::LD_IDLE: begin
				if (ld.start) begin
					next_prog  = ld.prog;
					next_cnt   = MIN_CYC - lsps_pkg::CNT_ONE;
					next_ch    = 4'h0;
					next_state = lsps_pkg::LD_WAIT;
				end
			end
			lsps_pkg::LD_WAIT: begin
				if (cnt == lsps_pkg::CNT_ZERO) begin
					next_state = lsps_pkg::LD_FETCH;
				end else begin
					next_cnt = cnt - lsps_pkg::CNT_ONE;
				end
			end
			lsps_pkg::LD_FETCH: begin
				next_state = lsps_pkg::LD_TAKE;
			end
			lsps_pkg::LD_TAKE: begin
				if (!ld.src_valid || ch == lsps_pkg::CH_LAST) begin
					next_state = lsps_pkg::LD_IDLE;
				end else begin
					next_ch    = ch + 4'h1;
					next_state = lsps_pkg::LD_FETCH;
				end
			end
			default: begin
				next_state = lsps_pkg::LD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= lsps_pkg::LD_IDLE;
			cnt   <= lsps_pkg::CNT_ZERO;
			ch    <= 4'h0;
			prog  <= 4'h0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			ch    <= next_ch;
			prog  <= next_prog;
		end
	end

	// A rejected program stops the walk at the first invalid channel; earlier channels are already overwritten.
	assign ld.busy     = (state != lsps_pkg::LD_IDLE);
	assign ld.wr_en    = (state == lsps_pkg::LD_TAKE) && ld.src_valid;
	assign ld.done     = ld.wr_en && (ch == lsps_pkg::CH_LAST);
	assign ld.fail     = (state == lsps_pkg::LD_TAKE) && !ld.src_valid;
	assign ld.err_code = lsps_pkg::ERR_BASE + {4'h0, prog};
	assign ld.ch       = ch;
	assign ld.ch_prog  = prog;

endmodule : lsps_loader

/* File: verilog/lsps_top.sv */
// Cam switch program selector: online control, program switching and cam outputs.
// Assumes a classic Wishbone master and a program store answering within one cycle.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module lsps_top #(
	parameter logic [26:0] STARTUP_CYC    = lsps_pkg::STARTUP_CYC,
	parameter logic [26:0] SWITCH_MIN_CYC = lsps_pkg::SWITCH_MIN_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output      logic [31:0] dat_o,
	output      logic        ack_o,
	// Host and position
	input  wire logic        host_ready_input_i,
	input  wire logic [15:0] position_i,
	// Stored program read port
	output      logic [7:0]  store_addr_o,
	input  wire logic [15:0] store_on_i,
	input  wire logic [15:0] store_off_i,
	input  wire logic        store_valid_i,
	// Status and cam outputs
	output      logic        online_o,
	output      logic [15:0] cam_switch_o
);
	lsps_load_if ld ();

	lsps_loader #(
		.MIN_CYC (SWITCH_MIN_CYC)
	) u_loader (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ld    (ld.loader)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [5:0]  idx;
	logic        acc;
	logic        wr_acc;
	logic [5:0]  dog_off;
	logic [3:0]  dog_ch;
	logic        dog_hit;

	assign idx     = adr_i[7:2];
	assign acc     = cyc_i && stb_i && !ack_o;
	assign wr_acc  = acc && we_i;
	assign dog_hit = (idx >= lsps_pkg::IDX_DOG_BASE) && (idx <= lsps_pkg::IDX_DOG_LAST);
	assign dog_off = idx - lsps_pkg::IDX_DOG_BASE;
	assign dog_ch  = dog_off[4:1];

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	// ----------------------------------------------------------------
	// Start-up block and online state
	// ----------------------------------------------------------------
	logic [26:0] blk_cnt, next_blk_cnt;
	logic        online, next_online;
	logic        was_online, next_was_online;

	always_comb begin
		next_blk_cnt    = blk_cnt;
		next_was_online = online;
		if (blk_cnt != lsps_pkg::CNT_ZERO) begin
			next_blk_cnt = blk_cnt - lsps_pkg::CNT_ONE;
		end
		next_online = host_ready_input_i && (blk_cnt == lsps_pkg::CNT_ZERO);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blk_cnt    <= STARTUP_CYC;
			online     <= 1'b0;
			was_online <= 1'b0;
		end else begin
			blk_cnt    <= next_blk_cnt;
			online     <= next_online;
			was_online <= next_was_online;
		end
	end

	// ----------------------------------------------------------------
	// Program control
	// ----------------------------------------------------------------
	logic [15:0] prog_set, next_prog_set;
	logic [15:0] last_req, next_last_req;
	logic [15:0] answer, next_answer;
	logic [7:0]  err_code, next_err_code;
	logic        pend, next_pend;
	logic        start, next_start;
	logic [3:0]  prog, next_prog;
	logic        act_valid, next_act_valid;
	logic        go;

	// A switch request waits while a walk is under way and is taken afterwards.
	assign go = online && !ld.busy && !start && (pend || prog_set != last_req);

	always_comb begin
		next_prog_set  = prog_set;
		next_last_req  = last_req;
		next_answer    = answer;
		next_err_code  = err_code;
		next_pend      = pend;
		next_start     = 1'b0;
		next_prog      = prog;
		next_act_valid = act_valid;
		if (wr_acc && idx == lsps_pkg::IDX_PROG_SET) begin
			next_prog_set = merge(prog_set, dat_i, sel_i);
		end
		if (online && !was_online) begin
			next_pend = 1'b1;
		end
		if (go) begin
			next_pend     = 1'b0;
			next_last_req = prog_set;
			if (prog_set <= lsps_pkg::PROG_MAX) begin
				next_start = 1'b1;
				next_prog  = prog_set[3:0];
				if (prog_set == lsps_pkg::PROG_ZERO) begin
					next_answer = lsps_pkg::ANS_SWITCHING;
				end
			end
		end
		if (ld.done) begin
			next_answer    = {12'h000, ld.ch_prog};
			next_err_code  = lsps_pkg::ERR_NONE;
			next_act_valid = 1'b1;
		end
		if (ld.fail) begin
			next_err_code = ld.err_code;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_set  <= lsps_pkg::PROG_SET_RST;
			last_req  <= lsps_pkg::PROG_SET_RST;
			answer    <= lsps_pkg::ANS_RST;
			err_code  <= lsps_pkg::ERR_NONE;
			pend      <= 1'b0;
			start     <= 1'b0;
			prog      <= 4'h0;
			act_valid <= 1'b0;
		end else begin
			prog_set  <= next_prog_set;
			last_req  <= next_last_req;
			answer    <= next_answer;
			err_code  <= next_err_code;
			pend      <= next_pend;
			start     <= next_start;
			prog      <= next_prog;
			act_valid <= next_act_valid;
		end
	end

	assign ld.start     = start;
	assign ld.prog      = prog;
	assign ld.src_valid = (ld.ch_prog == 4'h0) || store_valid_i;
	assign store_addr_o = {ld.ch_prog, ld.ch};

	// ----------------------------------------------------------------
	// Dog buffer, active table and cam outputs, one set per channel
	// ----------------------------------------------------------------
	logic [15:0] buf_on  [lsps_pkg::CH_NUM];
	logic [15:0] buf_off [lsps_pkg::CH_NUM];
	logic [15:0] act_on  [lsps_pkg::CH_NUM];
	logic [15:0] act_off [lsps_pkg::CH_NUM];
	logic [15:0] next_cam;
	logic [15:0] src_on;
	logic [15:0] src_off;

	assign src_on  = (ld.ch_prog == 4'h0) ? buf_on[ld.ch] : store_on_i;
	assign src_off = (ld.ch_prog == 4'h0) ? buf_off[ld.ch] : store_off_i;

	genvar c;
	generate
		for (c = 0; c < lsps_pkg::CH_NUM; c++) begin : g_ch
			logic [15:0] nb_on, nb_off, na_on, na_off;
			logic        hit;
			logic        in_span;

			assign hit = wr_acc && dog_hit && (dog_ch == 4'(c));

			always_comb begin
				nb_on  = buf_on[c];
				nb_off = buf_off[c];
				na_on  = act_on[c];
				na_off = act_off[c];
				if (hit && !dog_off[0]) begin
					nb_on = merge(buf_on[c], dat_i, sel_i);
				end
				if (hit && dog_off[0]) begin
					nb_off = merge(buf_off[c], dat_i, sel_i);
				end
				// Only a walk of the loader touches the active table.
				if (ld.wr_en && ld.ch == 4'(c)) begin
					na_on  = src_on;
					na_off = src_off;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					buf_on[c]  <= lsps_pkg::DOG_RST;
					buf_off[c] <= lsps_pkg::DOG_RST;
					act_on[c]  <= lsps_pkg::DOG_RST;
					act_off[c] <= lsps_pkg::DOG_RST;
				end else begin
					buf_on[c]  <= nb_on;
					buf_off[c] <= nb_off;
					act_on[c]  <= na_on;
					act_off[c] <= na_off;
				end
			end

			// A span whose off point lies below its on point wraps past the top.
			always_comb begin
				if (act_on[c] < act_off[c]) begin
					in_span = (position_i >= act_on[c]) && (position_i < act_off[c]);
				end else if (act_on[c] > act_off[c]) begin
					in_span = (position_i >= act_on[c]) || (position_i < act_off[c]);
				end else begin
					in_span = 1'b0;
				end
				next_cam[c] = online && act_valid && in_span;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Bus answer and registered outputs
	// ----------------------------------------------------------------
	logic [31:0] next_dat;
	logic [15:0] status;

	always_comb begin
		status                          = {8'h00, err_code};
		status[lsps_pkg::ST_ONLINE_BIT] = online;
		status[lsps_pkg::ST_BUSY_BIT]   = ld.busy || start;
		status[lsps_pkg::ST_VALID_BIT]  = act_valid;
		next_dat                        = 32'h00000000;
		if (acc && !we_i) begin
			if (dog_hit) begin
				next_dat = {16'h0000, dog_off[0] ? buf_off[dog_ch] : buf_on[dog_ch]};
			end else begin
				case (idx)
					lsps_pkg::IDX_PROG_SET:  next_dat = {16'h0000, prog_set};
					lsps_pkg::IDX_ANSWER:    next_dat = {16'h0000, answer};
					lsps_pkg::IDX_CAM_STATE: next_dat = {16'h0000, cam_switch_o};
					lsps_pkg::IDX_STATUS:    next_dat = {16'h0000, status};
					default:                 next_dat = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o        <= 1'b0;
			dat_o        <= 32'h00000000;
			cam_switch_o <= 16'h0000;
			online_o     <= 1'b0;
		end else begin
			ack_o        <= acc;
			dat_o        <= next_dat;
			cam_switch_o <= next_cam;
			online_o     <= online;
		end
	end

endmodule : lsps_top

/* File: bench/lsps_top_sva.sv */
// Port-level checks of the cam switch program selector.
// Assumes it is bound to lsps_top and given the same timing parameters.
`timescale 1ns/1ps
module lsps_top_sva #(
	parameter logic [26:0] STARTUP_CYC    = lsps_pkg::STARTUP_CYC,
	parameter logic [26:0] SWITCH_MIN_CYC = lsps_pkg::SWITCH_MIN_CYC
) (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Host and outputs
	input wire logic        host_ready_input_i,
	input wire logic        online_o,
	input wire logic [15:0] cam_switch_o
);
	// ----------------------------------------------------------------
	// Cycle counters since reset release and while online
	// ----------------------------------------------------------------
	int unsigned up_cnt;
	int unsigned on_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			up_cnt <= 0;
			on_cnt <= 0;
		end else begin
			if (up_cnt < 32'h0000FFFF) up_cnt <= up_cnt + 1;
			if (online_o && on_cnt < 32'h0000FFFF) on_cnt <= on_cnt + 1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	property p_ack_answer;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acked next cycle");

	property p_dat_idle;
		!ack_o |-> dat_o == 32'h00000000;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

	property p_startup;
		online_o |-> up_cnt >= 32'(STARTUP_CYC);
	endproperty
	a_startup: assert property (p_startup) else $error("online during startup");

	property p_online_on;
		(host_ready_input_i [*3]) ##0 (up_cnt > 32'(STARTUP_CYC) + 8) |-> online_o;
	endproperty
	a_online_on: assert property (p_online_on) else $error("ready without online");

	property p_online_off;
		(!host_ready_input_i) [*3] |-> !online_o;
	endproperty
	a_online_off: assert property (p_online_off) else $error("online without ready");

	property p_cam_offline;
		!online_o && !$past(online_o) |-> cam_switch_o == 16'h0000;
	endproperty
	a_cam_offline: assert property (p_cam_offline) else $error("cam on while offline");

	property p_cam_loaded;
		cam_switch_o != 16'h0000 |-> on_cnt > 32'(SWITCH_MIN_CYC);
	endproperty
	a_cam_loaded: assert property (p_cam_loaded) else $error("cam on before a load");
endmodule : lsps_top_sva

/* File: bench/lsps_store_model.sv */
// Stored cam programs 1 to 7 hold data; program 8 is left invalid.
// Assumes the address is registered and data answer the cycle after it changes.
`timescale 1ns/1ps
module lsps_store_model (
	// Clock
	input  wire logic        clk_i,
	// Read port
	input  wire logic [7:0]  store_addr_i,
	output      logic [15:0] store_on_o,
	output      logic [15:0] store_off_o,
	output      logic        store_valid_o
);
	logic [7:0]  addr_q;
	logic [15:0] junk = 16'hA5A5;

	always_ff @(posedge clk_i) begin
		addr_q <= store_addr_i;
		junk <= ~junk;
	end

	// Channel c of program p is on from {p,c,0} up to 8 positions later.
	always_comb begin
		store_valid_o = addr_q[7:4] != 4'h0 && addr_q[7:4] < 4'h8;
		store_on_o = store_valid_o ? {4'h0, addr_q, 4'h0} : junk;
		store_off_o = store_valid_o ? {4'h0, addr_q, 4'h8} : ~junk;
	end
endmodule : lsps_store_model

/* File: bench/lsps_top_tb.sv */
// Self-checking bench of the cam switch program selector over Wishbone.
// Assumes short startup and switch times set through the top parameters.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module lsps_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        host_ready_input_i = 1'b0;
	logic [15:0] position_i = 16'h0000;
	logic [7:0]  store_addr_o;
	logic [15:0] store_on_i;
	logic [15:0] store_off_i;
	logic        store_valid_i;
	logic        online_o;
	logic [15:0] cam_switch_o;
	int unsigned n_fail = 0;
	int unsigned n_checks = 0;
	int unsigned cyc_cnt = 0;
	int unsigned t0;
	int unsigned dt;
	logic [15:0] v;

	lsps_top #(.STARTUP_CYC(27'h0000014), .SWITCH_MIN_CYC(27'h0000004)) u_lsps_top (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.host_ready_input_i(host_ready_input_i), .position_i(position_i),
		.store_addr_o(store_addr_o), .store_on_i(store_on_i), .store_off_i(store_off_i),
		.store_valid_i(store_valid_i), .online_o(online_o), .cam_switch_o(cam_switch_o));

	lsps_store_model u_lsps_store_model (.clk_i(clk_i), .store_addr_i(store_addr_o),
		.store_on_o(store_on_i), .store_off_o(store_off_i), .store_valid_o(store_valid_i));

	always #2.5 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt > 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Bus and wait tasks
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [5:0] idx, input logic [15:0] wd);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		sel_i <= 4'h3;
		dat_i <= {16'h0000, wd};
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		v = dat_o[15:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	task automatic rd_chk(input logic [5:0] idx, input logic [15:0] e);
		wb(1'b0, idx, 16'h0000);
		`CHK(v, e)
	endtask : rd_chk

	task automatic wait_done();
		logic seen;
		int k;
		seen = 1'b0;
		for (k = 0; k < 100; k++) begin
			wb(1'b0, 6'h07, 16'h0000);
			if (v[9] === 1'b1) seen = 1'b1;
			else if (seen) break;
		end
		`CHK(seen && v[9] === 1'b0, 1'b1)
		dt = cyc_cnt - t0;
	endtask : wait_done

	task automatic sel_prog(input logic [15:0] p);
		t0 = cyc_cnt;
		wb(1'b1, 6'h09, p);
		wait_done();
	endtask : sel_prog

	task automatic wait_online();
		int k;
		for (k = 0; k < 200 && online_o !== 1'b1; k++) @(posedge clk_i);
		`CHK(online_o, 1'b1)
	endtask : wait_online

	task automatic cam_chk(input logic [15:0] pos, input logic [15:0] e);
		@(posedge clk_i);
		position_i <= pos;
		repeat (3) @(posedge clk_i);
		`CHK(cam_switch_o, e)
	endtask : cam_chk

	task automatic report_and_stop();
		if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		host_ready_input_i <= 1'b1;
		t0 = cyc_cnt;
		rd_chk(6'h09, 16'h0000);
		rd_chk(6'h3F, 16'h0000);
		wb(1'b1, 6'h01, 16'hFFFF);
		rd_chk(6'h01, 16'h0000);
		wb(1'b1, 6'h09, 16'h0003);
		cam_chk(16'h0332, 16'h0000);
		`CHK(online_o, 1'b0)
		wait_online();
		`CHK((cyc_cnt - t0) > 32'd20, 1'b1)
		wait_done();
		rd_chk(6'h01, 16'h0003);
		cam_chk(16'h0332, 16'h0008);
		for (int p = 1; p <= 8; p++) begin
			sel_prog(16'(p));
			`CHK(dt > 32'd4, 1'b1)
			rd_chk(6'h01, p == 8 ? 16'h0007 : 16'(p));
			rd_chk(6'h09, 16'(p));
			wb(1'b0, 6'h07, 16'h0000);
			`CHK(v[7:0], p == 8 ? 8'h44 : 8'h00)
			if (p < 8) cam_chk({4'h0, 4'(p), 4'(p), 4'h2}, 16'h0001 << p);
		end
		wb(1'b1, 6'h10, 16'h0100);
		wb(1'b1, 6'h11, 16'h0200);
		t0 = cyc_cnt;
		wb(1'b1, 6'h09, 16'h0000);
		rd_chk(6'h01, 16'h0009);
		wait_done();
		rd_chk(6'h01, 16'h0000);
		cam_chk(16'h0150, 16'h0004);
		wb(1'b1, 6'h10, 16'h1000);
		wb(1'b1, 6'h11, 16'h2000);
		cam_chk(16'h0150, 16'h0004);
		wb(1'b1, 6'h09, 16'h0009);
		rd_chk(6'h01, 16'h0000);
		sel_prog(16'h0000);
		cam_chk(16'h0150, 16'h0000);
		cam_chk(16'h1500, 16'h0004);
		host_ready_input_i <= 1'b0;
		cam_chk(16'h1500, 16'h0000);
		wb(1'b1, 6'h10, 16'h0100);
		wb(1'b1, 6'h11, 16'h0200);
		host_ready_input_i <= 1'b1;
		wait_online();
		wait_done();
		cam_chk(16'h0150, 16'h0004);
		rd_chk(6'h04, 16'h0004);
		wb(1'b0, 6'h07, 16'h0000);
		`CHK(v[10:8], 3'b101)
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(6'h09, 16'h0000);
		rd_chk(6'h10, 16'h0000);
		`CHK(online_o, 1'b0)
		wait_online();
		wait_done();
		cam_chk(16'h0150, 16'h0000);
		report_and_stop();
	end
endmodule : lsps_top_tb

bind lsps_top lsps_top_sva #(.STARTUP_CYC(STARTUP_CYC), .SWITCH_MIN_CYC(SWITCH_MIN_CYC))
	u_lsps_top_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.dat_o(dat_o), .ack_o(ack_o), .host_ready_input_i(host_ready_input_i),
	.online_o(online_o), .cam_switch_o(cam_switch_o));
